// ==== hw/irq_output_consts.vh ====
// Constants for the interrupt output controller
`ifndef IRQ_OUTPUT_CONSTS_VH
`define IRQ_OUTPUT_CONSTS_VH
`define CHIP_IDENTITY_REVISION_OFFSET      8'h50
`define IRQ_CFG_OFFSET     8'h54
`define SOURCE_STATUS_BITS_OFFSET     8'h58
`define INT_EN_OFFSET      8'h5c
`define CFG_DEAS_MSB       31
`define CFG_DEAS_LSB       24
`define CFG_RESTART_BIT    14
`define CFG_ACTIVE_BIT     13
`define CFG_MASTER_BIT     12
`define CFG_ENABLE_BIT     8
`define CFG_POL_BIT        4
`define CFG_TYPE_BIT       0
`define PME_SRC_BIT        17
`define CFG_RESET          32'h00000000
`define CHIP_ID_DEFAULT    16'h5a5a
`define CHIP_REV_DEFAULT   16'h00a1
`define CLK_HZ             25000000
`define TICK_TIME_US       10
`define TICK_CYCLES        ((`CLK_HZ / 1000000) * `TICK_TIME_US)
`endif

// ==== hw/tick_divider.v ====
// Divider making a one-cycle enable every deassertion tick
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter integer CYCLES = 250
) (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire restart_in,
  output wire tick_out
);
  reg [15:0] count_q;
  wire [15:0] last_c = CYCLES[15:0] - 16'h0001;
  assign tick_out = (count_q == last_c) & ~restart_in;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= 16'h0000;
    end else if (restart_in || count_q == last_c) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_q + 16'h0001;
    end
  end
endmodule // tick_divider
`default_nettype wire

// ==== hw/irq_output_controller.v ====
// Interrupt output controller with deassertion interval
// Behaviour
// RULE1 - Read-only identity: design id high, revision low
// RULE2 - Bits 31:24 set interval in 10 us
// RULE3 - Writing zero disables, resets, releases pending
// RULE4 - New nonzero interval applies to later interrupts
// RULE5 - Power event interrupt bypasses the interval
// RULE6 - Bit 14 restarts interval, self-clears
// RULE7 - Bit 13 shows interval in progress
// RULE8 - Bit 12 shows combined enabled interrupt line
// RULE9 - Bit 8 gates pin, status unaffected
// RULE10 - Bit 4 polarity, push-pull only
// RULE11 - Bit 0 selects open-drain or push-pull
// RULE12 - Write one clears status bits
// RULE13 - Interval starts when output falls, ticks counted
`include "irq_output_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module irq_output_controller #(
  parameter [15:0] CHIP_ID  = `CHIP_ID_DEFAULT,  // Arbitrary value
  parameter [15:0] CHIP_REV = `CHIP_REV_DEFAULT, // Arbitrary value
  parameter integer TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [7:0]  addr_in,
  input  wire        wr_in,
  input  wire        rd_in,
  input  wire [31:0] wdata_in,
  output reg  [31:0] rdata_out,
  input  wire [31:0] source_set_in,
  output wire        irq_out,
  output wire        irq_oe_n_out
);
  reg  [31:0] source_status_bits_q;
  reg  [31:0] enable_q;
  reg  [7:0]  deassert_interval_q;
  reg         irq_enable_q;
  reg         interrupt_pin_polarity_q;
  reg         push_pull_q;
  reg         deassert_interval_active_q;
  reg  [7:0]  tick_count_q;
  reg         asserted_q;
  reg         pin_q;
  reg         oe_n_q;
  reg         pin_d;
  reg         oe_n_d;
  wire [31:0] source_status_bits_d;
  wire [3:0]  sel_c;

  // Interval engine states
  localparam [0:0] IV_OPEN = 1'b0;
  localparam [0:0] IV_HOLD = 1'b1;

  // Register select codes, one-hot except SEL_NONE, which is all zero
  localparam [3:0] SEL_NONE = 4'h0;
  localparam [3:0] SEL_ID   = 4'h1;
  localparam [3:0] SEL_CFG  = 4'h2;
  localparam [3:0] SEL_STS  = 4'h4;
  localparam [3:0] SEL_EN   = 4'h8;

  // Shared by the write strobes and the read mux so both agree
  function [3:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `CHIP_IDENTITY_REVISION_OFFSET:  reg_sel = SEL_ID;
        `IRQ_CFG_OFFSET: reg_sel = SEL_CFG;
        `SOURCE_STATUS_BITS_OFFSET: reg_sel = SEL_STS;
        `INT_EN_OFFSET:  reg_sel = SEL_EN;
        default:         reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // Readback image; the restart bit is write-only and reads zero
  function [31:0] cfg_word;
    input [7:0] interval;
    input       active;
    input       line;
    input       enable;
    input       polarity;
    input       pushpull;
    begin
      cfg_word = `CFG_RESET;
      cfg_word[`CFG_DEAS_MSB:`CFG_DEAS_LSB] = interval;
      cfg_word[`CFG_ACTIVE_BIT] = active;
      cfg_word[`CFG_MASTER_BIT] = line;
      cfg_word[`CFG_ENABLE_BIT] = enable;
      cfg_word[`CFG_POL_BIT] = polarity;
      cfg_word[`CFG_TYPE_BIT] = pushpull;
    end
  endfunction

  assign sel_c = reg_sel(addr_in);
  wire wr_cfg = wr_in & (sel_c == SEL_CFG);
  wire wr_sts = wr_in & (sel_c == SEL_STS);
  wire wr_en  = wr_in & (sel_c == SEL_EN);
  wire [7:0] new_deas = wdata_in[`CFG_DEAS_MSB:`CFG_DEAS_LSB];
  wire restart = wr_cfg & wdata_in[`CFG_RESTART_BIT]; // see RULE6
  wire deas_off = wr_cfg & (new_deas == 8'h00); // see RULE3

  wire [31:0] active_src = source_status_bits_q & enable_q;
  wire master = |active_src; // see RULE8
  wire pme_active = active_src[`PME_SRC_BIT];
  // Power event reaches the pin even while withheld
  wire held_ok = master & ~deassert_interval_active_q;
  wire want = irq_enable_q & (held_ok | pme_active); // see RULE5 RULE9
  wire tick;
  // Falling output opens a new interval only when one is programmed
  wire fell_c = asserted_q & ~want & (deassert_interval_q != 8'h00);
  wire last_tick_c = (tick_count_q + 8'h01) >= deassert_interval_q;

  // Per-bit acknowledge; a new event in the clearing cycle wins
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_status
      assign source_status_bits_d[g] = source_set_in[g] |
        (source_status_bits_q[g] & ~(wr_sts & wdata_in[g])); // see RULE12
    end
  endgenerate

  tick_divider #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .restart_in (restart | ~deassert_interval_active_q),
    .tick_out   (tick)
  );

  // Sticky status, set beats clear
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      source_status_bits_q <= 32'h00000000;
      enable_q <= 32'h00000000;
    end else begin
      source_status_bits_q <= source_status_bits_d;
      if (wr_en) begin
        enable_q <= wdata_in;
      end
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      deassert_interval_q <= 8'h00;
      irq_enable_q <= 1'b0;
      interrupt_pin_polarity_q <= 1'b0;
      push_pull_q <= 1'b0;
    end else if (wr_cfg) begin
      deassert_interval_q <= new_deas; // see RULE2 RULE4
      irq_enable_q <= wdata_in[`CFG_ENABLE_BIT];
      interrupt_pin_polarity_q <= wdata_in[`CFG_POL_BIT];
      push_pull_q <= wdata_in[`CFG_TYPE_BIT];
    end
  end

  // Interval engine; length read live so later writes take effect
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      deassert_interval_active_q <= 1'b0;
      tick_count_q <= 8'h00;
      asserted_q <= 1'b0;
    end else begin
      asserted_q <= want;
      if (deas_off) begin
        deassert_interval_active_q <= IV_OPEN; // see RULE3
        tick_count_q <= 8'h00;
      end else if (restart) begin
        deassert_interval_active_q <= IV_HOLD; // see RULE6
        tick_count_q <= 8'h00;
      end else if (fell_c) begin
        deassert_interval_active_q <= IV_HOLD; // see RULE13
        tick_count_q <= 8'h00;
      end else begin
        case (deassert_interval_active_q)
          IV_OPEN: begin
            tick_count_q <= 8'h00;
          end
          IV_HOLD: begin
            if (tick && last_tick_c) begin
              deassert_interval_active_q <= IV_OPEN; // see RULE13
              tick_count_q <= 8'h00;
            end else if (tick) begin
              tick_count_q <= tick_count_q + 8'h01;
            end
          end
          default: begin
            deassert_interval_active_q <= IV_OPEN;
            tick_count_q <= 8'h00;
          end
        endcase
      end
    end
  end

  // Pin drive; open-drain always active low and released when idle
  always @* begin
    pin_d = 1'b1;
    oe_n_d = 1'b1;
    if (push_pull_q) begin
      pin_d = want ~^ interrupt_pin_polarity_q; // see RULE10
      oe_n_d = 1'b0;
    end else begin
      pin_d = 1'b0; // see RULE11
      oe_n_d = ~want;
    end
  end

  // Registered so the pin never glitches on decode hazards
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end
  assign irq_out = pin_q;
  assign irq_oe_n_out = oe_n_q;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (sel_c)
        SEL_ID: begin
          rdata_out <= {CHIP_ID, CHIP_REV}; // see RULE1
        end
        SEL_CFG: begin
          rdata_out <= cfg_word(deassert_interval_q,
            deassert_interval_active_q, master, irq_enable_q,
            interrupt_pin_polarity_q, push_pull_q); // see RULE7
        end
        SEL_STS: begin
          rdata_out <= source_status_bits_q;
        end
        SEL_EN: begin
          rdata_out <= enable_q;
        end
        default: begin
          rdata_out <= 32'h00000000;
        end
      endcase
    end
  end
endmodule // irq_output_controller
`default_nettype wire

// ==== test/irq_host_model.sv ====
// Host side of the interrupt pin
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
  input  wire logic irq_out,
  input  wire logic irq_oe_n_out,
  output wire logic pin_level
);
  // Pull-up holds a released wired-OR line high
  assign pin_level = irq_oe_n_out ? 1'b1 : irq_out;
endmodule // irq_host_model
`default_nettype wire

// ==== test/irq_output_controller_checker.sv ====
// Port checker for the interrupt output controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_output_consts.vh"
module irq_output_checker (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] wdata_in,
  input wire logic [31:0] rdata_out,
  input wire logic [31:0] source_set_in,
  input wire logic        irq_out,
  input wire logic        irq_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire c_w = wr_in && addr_in == 8'h54;
  wire c_r = rd_in && addr_in == 8'h54;
  chk_id_read: assert property (rd_in && addr_in == 8'h50 |=>
    rdata_out == {`CHIP_ID_DEFAULT, `CHIP_REV_DEFAULT}) else $error("id");
  chk_cfg_readback: assert property (c_w ##2 c_r |=>
    ((rdata_out ^ $past(wdata_in, 3)) & 32'hff000111) == 0) else $error("cfg");
  chk_restart_selfclear: assert property (c_r |=> !rdata_out[14])
    else $error("restart bit");
  chk_pp_drives: assert property (c_w && wdata_in[0] |-> ##2
    !irq_oe_n_out) else $error("push-pull");
  chk_od_released: assert property (c_w && wdata_in[8:0] == 0 |-> ##2
    irq_oe_n_out) else $error("released");
  chk_pp_idle_level: assert property (c_w && wdata_in[8:0] != 9'h101
    && wdata_in[0] && !wdata_in[8] |-> ##2 irq_out == !$past(wdata_in[4], 2))
    else $error("idle level");
  chk_status_clear: assert property (wr_in && addr_in == 8'h58 &&
    source_set_in == 0 ##1 source_set_in == 0 ##1 rd_in && addr_in == 8'h58
    |=> (rdata_out & $past(wdata_in, 3)) == 0) else $error("status clear");
  chk_od_low: assert property (c_w && !wdata_in[0] |-> ##2
    !irq_out) else $error("open-drain level");
  chk_unmapped_read: assert property (rd_in && addr_in == 8'h60 |=>
    rdata_out == 0) else $error("unmapped");
  cover property (c_w && wdata_in[0]);
  cover property (c_r ##1 rdata_out[13]);
  cover property ($fell(irq_oe_n_out));
endmodule // irq_output_checker
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the interrupt output controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_output_consts.vh"
module tb;
  logic        clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, source_set_in = 32'h0;
  wire  [31:0] rdata_out;
  wire         irq_out, irq_oe_n_out, pin_level;
  int          n_mismatch = 0, check_count = 0, cyc = 0;
  always #20 clk_in = ~clk_in;
  // Short tick keeps the interval test brief
  irq_output_controller #(.TICK_CYCLES(4)) dut_u (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out),
    .source_set_in(source_set_in), .irq_out(irq_out),
    .irq_oe_n_out(irq_oe_n_out));
  irq_host_model host_u (.irq_out(irq_out), .irq_oe_n_out(irq_oe_n_out),
    .pin_level(pin_level));
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_in) {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge clk_in) wr_in <= 0;
  endtask
  task rd(logic [7:0] a, logic [31:0] m, e);
    @(posedge clk_in) {addr_in, rd_in} <= {a, 1'b1};
    @(posedge clk_in) rd_in <= 0;
    @(posedge clk_in) #1 chk("rdata", e, rdata_out & m);
  endtask
  task src(logic [31:0] v);
    @(posedge clk_in) source_set_in <= v;
    @(posedge clk_in) source_set_in <= 0;
  endtask
  // Pin settles two edges after its cause
  task pin(logic e);
    repeat (3) @(posedge clk_in);
    #1 chk("pin", {31'h0, e}, {31'h0, pin_level});
  endtask
  task t_regs;
    rd(8'h50, '1, {`CHIP_ID_DEFAULT, `CHIP_REV_DEFAULT});
    wr(8'h50, 32'h0);
    rd(8'h50, '1, {`CHIP_ID_DEFAULT, `CHIP_REV_DEFAULT});
    wr(8'h54, 32'hff004111);
    rd(8'h54, 32'hff007111, 32'hff002111);
    wr(8'h54, 32'h0);
    rd(8'h54, '1, 32'h0);
    rd(8'h60, '1, 32'h0);
    $display("t_regs done");
  endtask
  task t_pin;
    wr(8'h5c, 32'h00020001);
    wr(8'h54, 32'h00000111);
    src(32'h1);
    pin(1);
    wr(8'h54, 32'h00000011);
    pin(0);
    rd(8'h54, 32'h1000, 32'h1000);
    wr(8'h54, 32'h00000101);
    pin(0);
    wr(8'h54, 32'h00000001);
    pin(1);
    wr(8'h54, 32'h00000110);
    pin(0);
    wr(8'h54, 32'h0);
    pin(1);
    wr(8'h58, 32'h1);
    rd(8'h58, '1, 32'h0);
    $display("t_pin done");
  endtask
  task t_interval;
    wr(8'h54, 32'h08000111);
    src(32'h1);
    pin(1);
    wr(8'h58, 32'h1);
    src(32'h1);
    pin(0);
    rd(8'h54, 32'h2000, 32'h2000);
    repeat (20) @(posedge clk_in);
    pin(0);
    pin(1);
    wr(8'h58, 32'h1);
    src(32'h20000);
    pin(1);
    wr(8'h58, 32'h20000);
    src(32'h1);
    pin(0);
    wr(8'h54, 32'h00000111);
    pin(1);
    $display("t_interval done");
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1;
    t_regs;
    t_pin;
    t_interval;
    stop_test;
  end
endmodule // tb
bind irq_output_controller irq_output_checker chk_u (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
  .wdata_in(wdata_in), .rdata_out(rdata_out), .source_set_in(source_set_in),
  .irq_out(irq_out), .irq_oe_n_out(irq_oe_n_out));
`default_nettype wire
